// ===== design/pm_ctrl_defs.svh
`ifndef PM_CTRL_DEFS_SVH
`define PM_CTRL_DEFS_SVH

`define CLK_PERIOD_NS     40
`define MS_NS             1000000
`define TICK_1MS_CYCLES   (`MS_NS / `CLK_PERIOD_NS)
`define ARM_TIME_MS       1000
`define MON_MIN_MS        1
`define WAKE_MIN_NS       500000
`define WAKE_MIN_CYCLES   ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KEEP_MIN_NS       150000
`define KEEP_MIN_CYCLES   ((`KEEP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             16
`define TIME_W            10
`define REL_SRC_WAKE      2'h0
`define REL_SRC_SYSTEM_UP_TRIGGER    2'h1
`define REL_SRC_POWER_UP_TRIGGER    2'h2
`define REL_SRC_LEAVE_RST 2'h3

`endif

// ===== design/pm_ctrl_pkg.sv
`include "pm_ctrl_defs.svh"

package pm_ctrl_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HOLD, KEY_ARMED, KEY_DONE} key_state_t;

  typedef struct packed {
    logic off_n;
    logic shut_n;
    logic key_n;
    logic pair_a_n;
    logic pair_b_n;
    logic sys;
    logic pwr;
    logic keep;
  } pins_t;

  typedef struct packed {
    logic               key_shutdown_enable;
    logic               input_pair_shutdown_enable;
    logic               host_shutdown_speed;
    logic               key_shutdown_speed;
    logic               soft_reset_select;
    logic               monitor_reset_enable;
    logic               auto_boot;
    logic               output_driver_type;
    logic               system_input_function;
    logic               system_input_polarity;
    logic               system_input_wake_enable;
    logic               power_input_function;
    logic               power_input_polarity;
    logic               power_input_wake_enable;
    logic               feedback1_function;
    logic               feedback1_polarity;
    logic               feedback2_function;
    logic               feedback2_polarity;
    logic [1:0]         reset_event;
    logic [`TIME_W-1:0] reset_time_ms;
    logic [`TIME_W-1:0] key_press_ms;
    logic [`TIME_W-1:0] hold_shutdown_time;
    logic [2:0]         keep_on;
  } pm_cfg_t;

  typedef struct packed {
    logic system_en_wr;
    logic system_en_val;
    logic power_en_wr;
    logic power_en_val;
    logic aux_power_en_wr;
    logic aux_power_en_val;
    logic key_reset_clear;
    logic fault_clear;
  } sw_cmd_t;

  typedef struct packed {
    logic seq_busy;
    logic dvc_active;
    logic in_powerdown;
    logic leaving_powerdown;
    logic cold_start;
    logic wakeup_valid;
    logic system_up;
    logic power_up;
    logic regs_in_range;
    logic monitoring_enabled;
    logic reg_out_of_range;
    logic otp_system_en;
  } pm_status_t;

  typedef struct packed {
    logic emergency_off;
    logic shutdown;
    logic shutdown_fast;
    logic to_reset_mode;
    logic system_down;
    logic power_down;
    logic start_sequencer;
    logic wakeup;
    logic irq_system;
    logic irq_power;
    logic key_nmi;
    logic watchdog_trigger;
  } seq_req_t;

  typedef struct packed {
    pins_t             sync1;
    pins_t             sync2;
    pins_t             prev;
    key_state_t        key_state;
    logic [`CNT_W-1:0] tick_cnt;
    logic [`CNT_W-1:0] hold_ms;
    logic [`CNT_W-1:0] rel_ms;
    logic [`CNT_W-1:0] asrt_ms;
    logic [`CNT_W-1:0] wake_cnt;
    logic [`CNT_W-1:0] keep_cnt;
    logic              shutdown_fault;
    logic              key_reset_flag;
    logic              in_reset_mode;
    logic              rst_asserted;
    logic              rel_running;
    logic              rst_o;
    logic              rst_oe;
    logic              sys_pin_seen;
    logic              pwr_pin_seen;
    logic              sw_sys_pending;
    logic              sw_sys_val;
    logic              sw_pwr_pending;
    logic              sw_pwr_val;
    logic              system_enable;
    logic              power_enable;
    logic              aux_power_enable;
    logic              wake_ind;
    logic              fb1_o;
    logic              fb2_o;
    logic              fb2_oe;
    logic [2:0]        use_b_voltage;
    seq_req_t          req;
  } state_t;

endpackage

// ===== design/power_manager_control_ports.sv
`timescale 1ns/100ps
`include "pm_ctrl_defs.svh"

module power_manager_control_ports
  import pm_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES     = `TICK_1MS_CYCLES,
  parameter int WAKE_MIN_CYCLES = `WAKE_MIN_CYCLES,
  parameter int ARM_TIME_MS     = `ARM_TIME_MS
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Pins from outside
  input  wire pins_t      pins,
  // Configuration, software commands, sequencer status
  input  wire pm_cfg_t    cfg,
  input  wire sw_cmd_t    sw,
  input  wire pm_status_t status,
  // Requests to sequencer and interrupt logic
  output seq_req_t        req,
  output logic [2:0]      use_b_voltage,
  // Flags
  output logic            shutdown_fault,
  output logic            key_reset_flag,
  output logic            in_reset_mode,
  output logic            system_enable,
  output logic            power_enable,
  output logic            aux_power_enable_bit,
  // Host reset pin
  output logic            host_reset_output,
  output logic            host_reset_output_oe,
  // Feedback pins
  output logic            feedback1_out,
  output logic            feedback2_out,
  output logic            feedback2_oe
);

  state_t s;
  state_t next_s;

  function automatic logic [`CNT_W-1:0] cnt_inc(input logic [`CNT_W-1:0] v);
    cnt_inc = (v == {`CNT_W{1'b1}}) ? v : v + `CNT_W'(1);
  endfunction

  function automatic logic active_level(input logic level, input logic active_high);
    active_level = active_high ? level : ~level;
  endfunction

  always_comb begin
    logic              tick;
    logic              key_hold;
    logic [`CNT_W-1:0] hold_limit;
    logic              rst_start;
    logic              rel_evt;
    logic              leave_evt;
    logic              wake_set;
    logic              sys_act;
    logic              pwr_act;
    logic              keepalive_input;
    logic              keep_was;
    logic              do_sys;
    logic              sys_val;
    logic              sys_pin;
    logic              do_pwr;
    logic              pwr_val;
    logic              pwr_pin;
    logic              busy;
    logic              good;
    tick       = 1'b0;
    key_hold   = 1'b0;
    hold_limit = '0;
    rst_start  = 1'b0;
    rel_evt    = 1'b0;
    leave_evt  = 1'b0;
    wake_set   = 1'b0;
    sys_act    = 1'b0;
    pwr_act    = 1'b0;
    keepalive_input   = 1'b0;
    keep_was   = 1'b0;
    do_sys     = 1'b0;
    sys_val    = 1'b0;
    sys_pin    = 1'b0;
    do_pwr     = 1'b0;
    pwr_val    = 1'b0;
    pwr_pin    = 1'b0;
    busy       = 1'b0;
    good       = 1'b0;

    next_s       = s;
    next_s.req   = '0;
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;

    // Millisecond tick
    tick = (s.tick_cnt == `CNT_W'(TICK_CYCLES - 1));
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + `CNT_W'(1);

    // Software clears first so that a hardware set in the same cycle wins
    if (sw.fault_clear) begin
      next_s.shutdown_fault = 1'b0;
    end
    if (sw.key_reset_clear) begin
      next_s.key_reset_flag = 1'b0;
    end

    // Hardware shutdown inputs, assertion edges
    if (s.prev.off_n && !s.sync2.off_n) begin
      next_s.shutdown_fault    = 1'b1;
      next_s.req.emergency_off = 1'b1;
      next_s.req.shutdown_fast = 1'b1;
      next_s.in_reset_mode     = 1'b1;
      rst_start                = 1'b1;
    end else if (s.prev.shut_n && !s.sync2.shut_n) begin
      next_s.shutdown_fault    = 1'b1;
      next_s.req.shutdown      = 1'b1;
      next_s.req.shutdown_fast = cfg.host_shutdown_speed;
      next_s.req.to_reset_mode = 1'b1;
      next_s.in_reset_mode     = 1'b1;
      rst_start                = 1'b1;
    end

    // Long key or input-pair hold
    key_hold = (cfg.key_shutdown_enable && !s.sync2.key_n) ||
               (cfg.input_pair_shutdown_enable && !s.sync2.pair_a_n && !s.sync2.pair_b_n);
    hold_limit = `CNT_W'({1'b0, cfg.key_press_ms} + {1'b0, cfg.hold_shutdown_time});
    case (s.key_state)
      KEY_IDLE: begin
        next_s.hold_ms = '0;
        if (key_hold) begin
          next_s.key_state = KEY_HOLD;
        end
      end
      KEY_HOLD: begin
        if (!key_hold) begin
          next_s.key_state = KEY_IDLE;
        end else if (s.hold_ms > hold_limit) begin
          next_s.key_state      = KEY_ARMED;
          next_s.key_reset_flag = 1'b1;
          next_s.req.key_nmi    = 1'b1;
          next_s.hold_ms        = '0;
        end else if (tick) begin
          next_s.hold_ms = cnt_inc(s.hold_ms);
        end
      end
      KEY_ARMED: begin
        if (!s.key_reset_flag) begin
          next_s.key_state = KEY_DONE;
        end else if (s.hold_ms > `CNT_W'(ARM_TIME_MS)) begin
          next_s.key_state         = KEY_DONE;
          next_s.req.shutdown      = 1'b1;
          next_s.req.shutdown_fast = cfg.key_shutdown_speed;
          next_s.req.to_reset_mode = 1'b1;
          next_s.in_reset_mode     = 1'b1;
          rst_start                = 1'b1;
        end else if (tick) begin
          next_s.hold_ms = cnt_inc(s.hold_ms);
        end
      end
      KEY_DONE: begin
        if (!key_hold) begin
          next_s.key_state = KEY_IDLE;
        end
      end
      default: begin
        next_s.key_state = KEY_IDLE;
      end
    endcase

    // Leaving reset mode after the shutdown has finished
    if (s.in_reset_mode && !rst_start && !status.seq_busy &&
        (status.wakeup_valid || cfg.auto_boot)) begin
      next_s.in_reset_mode       = 1'b0;
      next_s.req.start_sequencer = 1'b1;
      leave_evt                  = 1'b1;
    end

    // Enable changes, held while the sequencer works, except the system enable reload when leaving powerdown
    sys_act = active_level(s.sync2.sys, cfg.system_input_polarity);
    pwr_act = active_level(s.sync2.pwr, cfg.power_input_polarity);
    if (!status.seq_busy) begin
      if (cfg.system_input_function && sys_act != s.sys_pin_seen) begin
        next_s.sys_pin_seen = sys_act;
        do_sys              = 1'b1;
        sys_val             = sys_act;
        sys_pin             = 1'b1;
      end else if (s.sw_sys_pending) begin
        next_s.sw_sys_pending = 1'b0;
        do_sys                = 1'b1;
        sys_val               = s.sw_sys_val;
      end
      if (cfg.power_input_function && pwr_act != s.pwr_pin_seen) begin
        next_s.pwr_pin_seen = pwr_act;
        do_pwr              = 1'b1;
        pwr_val             = pwr_act;
        pwr_pin             = 1'b1;
      end else if (s.sw_pwr_pending) begin
        next_s.sw_pwr_pending = 1'b0;
        do_pwr                = 1'b1;
        pwr_val               = s.sw_pwr_val;
      end
      if (sw.aux_power_en_wr) begin
        next_s.aux_power_enable = sw.aux_power_en_val;
      end
    end
    if (sw.system_en_wr) begin
      next_s.sw_sys_pending = 1'b1;
      next_s.sw_sys_val     = sw.system_en_val;
    end
    if (sw.power_en_wr) begin
      next_s.sw_pwr_pending = 1'b1;
      next_s.sw_pwr_val     = sw.power_en_val;
    end

    if (do_sys && sys_val && !s.system_enable) begin
      next_s.system_enable = 1'b1;
      next_s.use_b_voltage = '0;
      if (sys_pin) begin
        next_s.req.irq_system = 1'b1;
        next_s.req.wakeup     = status.in_powerdown && cfg.system_input_wake_enable;
      end
    end else if (do_sys && !sys_val && s.system_enable) begin
      next_s.system_enable    = 1'b0;
      next_s.power_enable     = 1'b0;
      next_s.aux_power_enable = 1'b0;
      next_s.req.system_down  = 1'b1;
      next_s.use_b_voltage    = cfg.keep_on;
      if (sys_pin && cfg.soft_reset_select) begin
        rst_start = 1'b1;
      end
    end
    if (status.leaving_powerdown) begin
      next_s.system_enable = status.otp_system_en;
    end

    // Power domain enable; host keeps system enabled first
    if (do_pwr && pwr_val && !s.power_enable) begin
      next_s.power_enable = 1'b1;
      if (pwr_pin) begin
        next_s.req.irq_power = 1'b1;
        next_s.req.wakeup    = status.in_powerdown && cfg.power_input_wake_enable;
      end
    end else if (do_pwr && !pwr_val && s.power_enable) begin
      next_s.aux_power_enable = 1'b0;
      next_s.power_enable     = 1'b0;
      next_s.req.power_down   = 1'b1;
    end

    // First feedback pin: wakeup indicator or busy
    if (status.wakeup_valid && status.in_powerdown && !s.wake_ind) begin
      next_s.wake_ind = 1'b1;
      next_s.wake_cnt = '0;
      wake_set        = 1'b1;
    end else if (s.wake_ind) begin
      next_s.wake_cnt = cnt_inc(s.wake_cnt);
      if (s.system_enable && s.wake_cnt >= `CNT_W'(WAKE_MIN_CYCLES - 1)) begin
        next_s.wake_ind = 1'b0;
      end
    end
    busy = status.seq_busy || status.dvc_active;
    next_s.fb1_o = active_level(cfg.feedback1_function ? busy : next_s.wake_ind,
                                cfg.feedback1_polarity);

    // Second feedback pin: supply good or keepalive
    keepalive_input = active_level(s.sync2.keep, cfg.feedback2_polarity);
    keep_was = active_level(s.prev.keep, cfg.feedback2_polarity);
    next_s.keep_cnt = cnt_inc(s.keep_cnt);
    good = status.regs_in_range && status.monitoring_enabled;
    next_s.fb2_o = 1'b0;
    if (cfg.feedback2_function) begin
      next_s.fb2_oe = 1'b0;
      if (keepalive_input && !keep_was && s.keep_cnt >= `CNT_W'(`KEEP_MIN_CYCLES - 1)) begin
        next_s.req.watchdog_trigger = 1'b1;
        next_s.keep_cnt             = '0;
      end
    end else begin
      next_s.fb2_oe = !good;
    end

    // Host reset assertion and release timer
    if (status.cold_start) begin
      rst_start = 1'b1;
    end
    if (cfg.monitor_reset_enable && status.reg_out_of_range) begin
      rst_start = 1'b1;
    end
    case (cfg.reset_event)
      `REL_SRC_WAKE:     rel_evt = wake_set;
      `REL_SRC_SYSTEM_UP_TRIGGER:   rel_evt = status.system_up;
      `REL_SRC_POWER_UP_TRIGGER:   rel_evt = status.power_up;
      default:           rel_evt = leave_evt;
    endcase
    if (rst_start) begin
      next_s.rst_asserted = 1'b1;
      next_s.rel_running  = 1'b0;
      next_s.rel_ms       = '0;
      next_s.asrt_ms      = '0;
    end else if (s.rst_asserted) begin
      if (tick) begin
        next_s.asrt_ms = cnt_inc(s.asrt_ms);
      end
      if (!s.rel_running) begin
        if (rel_evt) begin
          next_s.rel_running = 1'b1;
        end
      end else begin
        if (tick) begin
          next_s.rel_ms = cnt_inc(s.rel_ms);
        end
        if (s.rel_ms > `CNT_W'(cfg.reset_time_ms) &&
            s.asrt_ms > `CNT_W'(`MON_MIN_MS)) begin
          next_s.rst_asserted = 1'b0;
          next_s.rel_running  = 1'b0;
        end
      end
    end
    next_s.rst_o  = !next_s.rst_asserted && !cfg.output_driver_type;
    next_s.rst_oe = next_s.rst_asserted || !cfg.output_driver_type;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s              <= '0;
      s.rst_asserted <= 1'b1;
      s.rst_oe       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign req                  = s.req;
  assign use_b_voltage        = s.use_b_voltage;
  assign shutdown_fault       = s.shutdown_fault;
  assign key_reset_flag       = s.key_reset_flag;
  assign in_reset_mode        = s.in_reset_mode;
  assign system_enable        = s.system_enable;
  assign power_enable         = s.power_enable;
  assign aux_power_enable_bit = s.aux_power_enable;
  assign host_reset_output    = s.rst_o;
  assign host_reset_output_oe = s.rst_oe;
  assign feedback1_out        = s.fb1_o;
  assign feedback2_out        = s.fb2_o;
  assign feedback2_oe         = s.fb2_oe;

endmodule

// ===== verification/pm_ctrl_properties.sv
`timescale 1ns/100ps
module pm_ctrl_properties
  import pm_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Inputs of the block
  input wire pins_t      pins,
  input wire pm_cfg_t    cfg,
  input wire sw_cmd_t    sw,
  input wire pm_status_t status,
  // Outputs of the block
  input wire seq_req_t   req,
  input wire logic [2:0] use_b_voltage,
  input wire logic       shutdown_fault,
  input wire logic       key_reset_flag,
  input wire logic       in_reset_mode,
  input wire logic       system_enable,
  input wire logic       power_enable,
  input wire logic       aux_power_enable_bit,
  input wire logic       host_reset_output,
  input wire logic       host_reset_output_oe,
  input wire logic       feedback1_out,
  input wire logic       feedback2_out,
  input wire logic       feedback2_oe
);
  logic        rst_on;
  logic        good;
  logic        busy;
  logic [15:0] held;
  assign rst_on = cfg.output_driver_type ? host_reset_output_oe : !host_reset_output;
  assign good   = status.regs_in_range && status.monitoring_enabled;
  assign busy   = status.seq_busy || status.dvc_active;
  // Cycles the host reset has been held
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      held <= 16'h0;
    end else begin
      held <= rst_on ? held + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_off_done;
    req.emergency_off && req.shutdown_fast && shutdown_fault;
  endsequence
  sequence s_shut_done;
    req.shutdown && req.to_reset_mode && shutdown_fault;
  endsequence
  a_off_fast: assert property ($fell(pins.off_n) |-> ##[2:4] s_off_done)
    else $error("emergency off not answered");
  a_shut_reverse: assert property ($fell(pins.shut_n) && pins.off_n |-> ##[2:4] s_shut_done)
    else $error("host shutdown not answered");
  a_fault_sticky: assert property (shutdown_fault && !sw.fault_clear |=> shutdown_fault)
    else $error("fault flag lost");
  a_reset_before_down: assert property (req.shutdown || req.emergency_off |-> ##[0:1] rst_on)
    else $error("host reset not asserted at shutdown");
  a_key_nmi: assert property ($rose(key_reset_flag) |-> ##[0:1] req.key_nmi)
    else $error("armed without nmi");
  a_key_source: assert property ($rose(key_reset_flag) |->
    (cfg.key_shutdown_enable && !pins.key_n) ||
    (cfg.input_pair_shutdown_enable && !pins.pair_a_n && !pins.pair_b_n))
    else $error("armed without enabled hold");
  a_reset_min_time: assert property ($fell(rst_on) |-> held >= TICK_CYCLES)
    else $error("host reset too short");
  a_sys_held: assert property (status.seq_busy && !status.leaving_powerdown
    |=> $stable(system_enable))
    else $error("system enable changed while busy");
  a_sys_drop: assert property ($fell(system_enable) |->
    req.system_down && !power_enable && use_b_voltage == cfg.keep_on)
    else $error("system drop incomplete");
  a_pwr_drop: assert property ($fell(power_enable) && system_enable |->
    req.power_down && !aux_power_enable_bit)
    else $error("power drop incomplete");
  a_busy_out: assert property (cfg.feedback1_function && $stable(cfg.feedback1_function)
    && $past(nrst) |-> feedback1_out == ($past(busy) == cfg.feedback1_polarity))
    else $error("busy output wrong");
  a_good_out: assert property (!cfg.feedback2_function && $stable(cfg.feedback2_function)
    && $past(nrst) |-> feedback2_oe == !$past(good))
    else $error("supply good output wrong");
endmodule

bind power_manager_control_ports pm_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES))
  u_pm_ctrl_properties (.clk_sys, .nrst, .pins, .cfg, .sw, .status, .req, .use_b_voltage,
  .shutdown_fault, .key_reset_flag, .in_reset_mode, .system_enable, .power_enable,
  .aux_power_enable_bit, .host_reset_output, .host_reset_output_oe, .feedback1_out,
  .feedback2_out, .feedback2_oe);

// ===== verification/pm_host_model.sv
`timescale 1ns/100ps
module pm_host_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // From the block and the bench
  input  wire logic key_nmi,
  input  wire logic cancel,
  // Host pins and commands
  output logic      sys,
  output logic      pwr,
  output logic      keep,
  output logic      key_reset_clear
);
  initial begin
    sys = 1'b0;
    pwr = 1'b0;
    keep = 1'b0;
    key_reset_clear = 1'b0;
  end
  // Cancel an armed key reset after 2 ms
  always @(posedge clk_sys) begin
    if (nrst && key_nmi && cancel) begin
      repeat (20) @(negedge clk_sys);
      key_reset_clear = 1'b1;
      @(negedge clk_sys);
      key_reset_clear = 1'b0;
    end
  end
  task automatic power_on();
    @(negedge clk_sys);
    sys = 1'b1;
    repeat (10) @(negedge clk_sys);
    pwr = 1'b1;
  endtask
  task automatic drop_pwr();
    @(negedge clk_sys);
    pwr = 1'b0;
  endtask
  task automatic drop_sys();
    @(negedge clk_sys);
    sys = 1'b0;
  endtask
  // High for 4 cycles, then low for gap cycles
  task automatic keep_pulse(input int gap);
    @(negedge clk_sys);
    keep = 1'b1;
    repeat (4) @(negedge clk_sys);
    keep = 1'b0;
    repeat (gap) @(negedge clk_sys);
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
`include "pm_ctrl_defs.svh"
module testbench
  import pm_ctrl_pkg::*;
;
  logic       clk_sys, nrst, off_n, shut_n, key_n, pa_n, pb_n, fault_clr, cancel;
  logic       m_sys, m_pwr, m_keep, m_clr, nmi, sw_wr, sw_val;
  pins_t      pins;
  pm_cfg_t    cfg;
  sw_cmd_t    sw;
  pm_status_t status;
  seq_req_t   req, seen;
  logic [2:0] use_b_voltage;
  logic       shutdown_fault, key_reset_flag, in_reset_mode, system_enable, power_enable;
  logic       aux_power_enable_bit, host_reset_output, host_reset_output_oe;
  logic       feedback1_out, feedback2_out, feedback2_oe;
  int         err_count, checks_done, n;
  assign pins = {off_n, shut_n, key_n, pa_n, pb_n, m_sys, m_pwr, m_keep};
  assign sw   = {sw_wr, sw_val, 4'h0, m_clr, fault_clr};
  assign nmi  = req.key_nmi;
  power_manager_control_ports #(.TICK_CYCLES(10), .WAKE_MIN_CYCLES(8), .ARM_TIME_MS(5))
    u_power_manager_control_ports (.clk_sys, .nrst, .pins, .cfg, .sw, .status, .req,
    .use_b_voltage, .shutdown_fault, .key_reset_flag, .in_reset_mode, .system_enable,
    .power_enable, .aux_power_enable_bit, .host_reset_output, .host_reset_output_oe,
    .feedback1_out, .feedback2_out, .feedback2_oe);
  pm_host_model u_pm_host_model (.clk_sys(clk_sys), .nrst(nrst), .key_nmi(nmi),
    .cancel(cancel), .sys(m_sys), .pwr(m_pwr), .keep(m_keep), .key_reset_clear(m_clr));
  always @(posedge clk_sys) seen <= seen | req;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timed_out();
    err_count++;
    $display("wrong value wait expected 1 seen 0");
    wrap_up();
  endtask
  task automatic wait_req(input logic [11:0] m, input int lim);
    n = 0;
    while (!(|(seen & m)) && n < lim) begin
      cyc(1);
      n++;
    end
    if (!(|(seen & m))) timed_out();
  endtask
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (host_reset_output !== lvl && n < 300) begin
      cyc(1);
      n++;
    end
    if (host_reset_output !== lvl) timed_out();
  endtask
  task automatic release_rst();
    status.system_up = 1'b1;
    cyc(1);
    status.system_up = 1'b0;
    wait_rst(1'b1);
    chk("release time", 16'h1, {15'h0, n > 20});
  endtask
  task automatic restart();
    seen = '0;
    status.wakeup_valid = 1'b1;
    cyc(1);
    status.wakeup_valid = 1'b0;
    wait_req(12'h020, 50);
    chk("reset mode left", 16'h0, {15'h0, in_reset_mode});
    release_rst();
  endtask
  task automatic t_reset();
    chk("reset at start", 16'h0, {15'h0, host_reset_output});
    release_rst();
    status.reg_out_of_range = 1'b1;
    cyc(1);
    status.reg_out_of_range = 1'b0;
    wait_rst(1'b0);
    chk("monitor reset", 16'h1, {15'h0, n < 5});
    release_rst();
    status.regs_in_range = 1'b1;
    cyc(3);
    chk("supply good", 16'h0, {15'h0, feedback2_oe});
    status.monitoring_enabled = 1'b0;
    cyc(3);
    chk("supply bad", 16'h1, {15'h0, feedback2_oe});
    $display("test reset done");
  endtask
  task automatic t_enables();
    status.in_powerdown = 1'b1;
    seen = '0;
    u_pm_host_model.power_on();
    wait_req(12'h004, 100);
    chk("sys on", 16'h7, {13'h0, system_enable, seen.irq_system, seen.wakeup});
    chk("pwr on", 16'h1, {15'h0, power_enable});
    status.in_powerdown = 1'b0;
    u_pm_host_model.drop_pwr();
    wait_req(12'h040, 100);
    chk("pwr off", 16'h0, {15'h0, power_enable});
    status.seq_busy = 1'b1;
    seen = '0;
    cfg.soft_reset_select = 1'b1;
    u_pm_host_model.drop_sys();
    cyc(20);
    chk("sys held", 16'h1, {15'h0, system_enable});
    chk("ready low", 16'h0, {15'h0, feedback1_out});
    status.seq_busy = 1'b0;
    wait_req(12'h080, 100);
    chk("sys off", 16'h5, {12'h0, system_enable, use_b_voltage});
    chk("no irq", 16'h0, {14'h0, seen.irq_system, seen.wakeup});
    chk("soft reset", 16'h0, {14'h0, host_reset_output, in_reset_mode});
    release_rst();
    status.seq_busy = 1'b1;
    {sw_wr, sw_val} = 2'h3;
    cyc(1);
    sw_wr = 1'b0;
    cyc(3);
    chk("sw held", 16'h0, 16'(system_enable));
    status.seq_busy = 1'b0;
    cyc(2);
    chk("sw write", 16'h1, 16'(system_enable));
    {cfg.feedback1_function, status.in_powerdown, status.wakeup_valid} = 3'h3;
    cyc(1);
    {status.in_powerdown, status.wakeup_valid} = 2'h0;
    cyc(6);
    chk("wake on", 16'h0, 16'(feedback1_out));
    cyc(3);
    chk("wake off", 16'h1, 16'(feedback1_out));
    cfg.feedback1_function = 1'b1;
    $display("test enables done");
  endtask
  task automatic t_key();
    seen = '0;
    pa_n = 1'b0;
    pb_n = 1'b0;
    cyc(100);
    chk("pair disabled", 16'h0, {15'h0, key_reset_flag});
    cancel = 1'b1;
    key_n = 1'b0;
    wait_req(12'h002, 200);
    chk("armed", 16'h1, {15'h0, key_reset_flag});
    key_n = 1'b1;
    cyc(100);
    chk("cancelled", 16'h0, {14'h0, seen.shutdown, key_reset_flag});
    cancel = 1'b0;
    seen = '0;
    cfg.input_pair_shutdown_enable = 1'b1;
    wait_req(12'h400, 300);
    chk("key shutdown", 16'h7, {13'h0, seen.to_reset_mode, seen.shutdown_fast,
      in_reset_mode});
    cyc(2);
    chk("reset on key", 16'h0, {15'h0, host_reset_output});
    pa_n = 1'b1;
    pb_n = 1'b1;
    cyc(20);
    chk("stays off", 16'h1, {15'h0, in_reset_mode});
    restart();
    $display("test key done");
  endtask
  task automatic t_off();
    seen = '0;
    off_n = 1'b0;
    wait_req(12'h800, 10);
    cyc(2);
    chk("off", 16'h7, {13'h0, seen.shutdown_fast, shutdown_fault, !host_reset_output});
    off_n = 1'b1;
    fault_clr = 1'b1;
    cyc(1);
    fault_clr = 1'b0;
    chk("fault cleared", 16'h0, {15'h0, shutdown_fault});
    restart();
    seen = '0;
    shut_n = 1'b0;
    wait_req(12'h400, 10);
    cyc(2);
    chk("shut", 16'hb, {12'h0, seen.to_reset_mode, seen.shutdown_fast, shutdown_fault,
      !host_reset_output});
    shut_n = 1'b1;
    restart();
    $display("test shutdown done");
  endtask
  task automatic t_keep();
    cfg.feedback2_function = 1'b1;
    u_pm_host_model.keep_pulse(3800);
    seen = '0;
    u_pm_host_model.keep_pulse(100);
    chk("keepalive", 16'h1, {15'h0, seen.watchdog_trigger});
    seen = '0;
    u_pm_host_model.keep_pulse(10);
    chk("keepalive close", 16'h0, {15'h0, seen.watchdog_trigger});
    $display("test keepalive done");
  endtask
  initial begin
    nrst = 1'b0;
    {off_n, shut_n, key_n, pa_n, pb_n} = 5'h1f;
    {fault_clr, cancel, sw_wr, sw_val, err_count, checks_done} = '0;
    seen = '0;
    status = '0;
    status.monitoring_enabled = 1'b1;
    cfg = '0;
    cfg.key_shutdown_enable = 1'b1;
    cfg.key_shutdown_speed = 1'b1;
    cfg.monitor_reset_enable = 1'b1;
    {cfg.system_input_function, cfg.system_input_polarity} = 2'h3;
    {cfg.system_input_wake_enable, cfg.power_input_function} = 2'h3;
    cfg.power_input_polarity = 1'b1;
    cfg.feedback1_function = 1'b1;
    cfg.reset_event = `REL_SRC_SYSTEM_UP_TRIGGER;
    cfg.reset_time_ms = 10'h2;
    cfg.key_press_ms = 10'h1;
    cfg.hold_shutdown_time = 10'h1;
    cfg.keep_on = 3'h5;
    cyc(12);
    nrst = 1'b1;
    cyc(4);
    t_reset();
    t_enables();
    t_key();
    t_off();
    t_keep();
    wrap_up();
  end
endmodule
